// *** hdl/tsp_pkg.sv ***
// tsp_pkg: constants and types for the temperature sensor serial register port.
// assumes a 250 MHz main clock and a two-wire serial link clocked by the bus master.
package tsp_pkg;

  // ****************************************************************
  // register selector values
  // ****************************************************************
  localparam logic [3:0] PTR_CAPABILITY = 4'h0;
  localparam logic [3:0] PTR_CONFIG = 4'h1;
  localparam logic [3:0] PTR_UPPER = 4'h2;
  localparam logic [3:0] PTR_LOWER = 4'h3;
  localparam logic [3:0] PTR_CRITICAL = 4'h4;
  localparam logic [3:0] PTR_AMBIENT = 4'h5;
  localparam logic [3:0] PTR_MAKER = 4'h6;
  localparam logic [3:0] PTR_PART = 4'h7;
  localparam logic [3:0] PTR_RESOLUTION = 4'h8;
  localparam logic [7:0] SELECTOR_RESET = 8'h00;

  // ****************************************************************
  // configuration field positions and masks
  // ****************************************************************
  localparam int CFG_EVT_MODE = 0;
  localparam int CFG_EVT_POL = 1;
  localparam int CFG_EVT_SEL = 2;
  localparam int CFG_EVT_CNT = 3;
  localparam int CFG_EVT_STAT = 4;
  localparam int CFG_INT_CLR = 5;
  localparam int CFG_WIN_LOCK = 6;
  localparam int CFG_CRIT_LOCK = 7;
  localparam int CFG_POWER_DOWN = 8;
  localparam logic [15:0] CFG_WR_MASK = 16'h070F;
  localparam logic [15:0] CFG_LOCK_MASK = 16'h00C0;
  localparam logic [15:0] CFG_RESET = 16'h0000;

  // ****************************************************************
  // fixed contents, masks and reset values
  // ****************************************************************
  localparam logic [15:0] CAP_FIXED = 16'h00E7;
  localparam int CAP_RES_LSB = 3;
  localparam logic [15:0] LIMIT_MASK = 16'h1FFC;
  localparam logic [15:0] LIMIT_RESET = 16'h0000;
  localparam logic [12:0] AMBIENT_RESET = 13'h0000;
  localparam logic [1:0] RESOLUTION_RESET = 2'h1;
  localparam logic [3:0] SENSOR_ADDR_HI = 4'h3;

  // ****************************************************************
  // idle clock timeout, in microseconds and main clock cycles
  // ****************************************************************
  localparam int MCLK_FREQ_MHZ = 250;
  localparam int IDLE_CLOCK_TIMEOUT_MIN_US = 25000;
  localparam int IDLE_CLOCK_TIMEOUT_MAX_US = 35000;
  localparam int IDLE_CLOCK_TIMEOUT_US = 30000;
  localparam int IDLE_CLOCK_TIMEOUT_CYCLES = IDLE_CLOCK_TIMEOUT_US * MCLK_FREQ_MHZ;

  // ****************************************************************
  // synchroniser lanes into the main clock domain
  // ****************************************************************
  localparam int SYNC_W = 4;
  localparam int SYNC_SCL = 0;
  localparam int SYNC_SDA = 1;
  localparam int SYNC_XFER = 2;
  localparam int SYNC_READ = 3;
  localparam logic [3:0] SYNC_RESET = 4'h3;

  // word handed from the link to the register file
  typedef struct packed {
    logic isData;
    logic [15:0] word;
  } tsp_xfer_t;

endpackage : tsp_pkg

// *** hdl/tsp_serial_port.sv ***
// tsp_serial_port: two-wire slave port and register file of a temperature sensor.
// assumes the serial clock pin is also routed as a clock, open-drain pins resolved
// outside, and an external converter delivering readings with a done pulse.
`timescale 1ns/100ps
`default_nettype none

module tsp_serial_port #(
  parameter int unsigned TIMEOUT_CYCLES = tsp_pkg::IDLE_CLOCK_TIMEOUT_CYCLES,
  parameter logic [15:0] MAKER_ID = 16'h0A5A, // arbitrary value
  parameter logic [15:0] PART_ID_REV = 16'h3C01 // arbitrary value
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic serialClock,
  input wire logic sdaIn,
  output var logic sdaOut,
  output var logic sdaOe,
  input wire logic [2:0] addrSelect,
  input wire logic [12:0] ambientReading,
  input wire logic conversionDone,
  output var logic eventOut,
  output var logic eventOe,
  output var logic powerDownSelect,
  output var logic [1:0] resolutionSelect
);

  // ****************************************************************
  // elaboration checks
  // ****************************************************************
  if (TIMEOUT_CYCLES < 2) begin : gBadTimeout
    $error("TIMEOUT_CYCLES must be at least 2");
  end

  typedef enum logic [2:0] {PH_ADDR, PH_PTR, PH_WDATA, PH_RDATA, PH_IGNORE} tsp_phase_t;

  // ****************************************************************
  // declarations
  // ****************************************************************
  tsp_phase_t phase;
  logic [3:0] bitCnt;
  logic [6:0] shiftIn;
  logic ackIt;
  logic byteSel;
  logic [7:0] msbHold;
  tsp_pkg::tsp_xfer_t xfer;
  logic xferTgl;
  logic readTgl;
  logic linkRst;
  logic [7:0] byteNow;
  logic addrHit;
  logic byteDone;
  logic ackSlot;
  logic txBit;
  logic [tsp_pkg::SYNC_W-1:0] syncIn;
  logic [tsp_pkg::SYNC_W-1:0] filt;
  logic [tsp_pkg::SYNC_W-1:0] prevFilt;
  logic busy;
  logic [31:0] idleTimer;
  logic startSeen;
  logic stopSeen;
  logic sclEdge;
  logic timeoutHit;
  logic xferEvt;
  logic readEvt;
  logic [7:0] selector;
  logic [15:0] cfg;
  logic [15:0] upperLimit;
  logic [15:0] lowerLimit;
  logic [15:0] criticalLimit;
  logic [12:0] ambient;
  logic [1:0] resolution;
  logic [15:0] snapshot;
  logic evtLatch;
  logic [15:0] regView [16];
  logic [15:0] readWord;
  logic dataWrite;
  logic wrCfg;
  logic wrUpper;
  logic wrLower;
  logic wrCrit;
  logic wrRes;
  logic intClear;
  logic aboveUpper;
  logic belowLower;
  logic atCrit;
  logic evtCond;
  logic evtActive;
  logic [15:0] next_cfg;

  // ****************************************************************
  // link domain: byte reception on the rising serial clock
  // ****************************************************************
  // byte as it completes on the eighth rising edge
  assign byteNow = {shiftIn, sdaIn};
  assign addrHit = byteNow[7:1] == {tsp_pkg::SENSOR_ADDR_HI, addrSelect};
  assign byteDone = bitCnt == 4'h7;
  assign ackSlot = bitCnt == 4'h8;

  // bit counter, phase and acknowledge decision; start, stop and timeout clear it
  always_ff @(posedge serialClock or posedge linkRst) begin
    if (linkRst) begin
      phase <= PH_ADDR;
      bitCnt <= 4'h0;
      shiftIn <= 7'h00;
      ackIt <= 1'b0;
      byteSel <= 1'b0;
      msbHold <= 8'h00;
    end else if (ackSlot) begin
      bitCnt <= 4'h0;
      ackIt <= 1'b0;
      if (phase == PH_RDATA && !ackIt) begin
        if (sdaIn) begin
          phase <= PH_IGNORE;
        end else begin
          byteSel <= ~byteSel;
        end
      end
    end else begin
      shiftIn <= byteNow[6:0];
      bitCnt <= 4'(bitCnt + 4'h1);
      if (byteDone) begin
        unique case (phase)
          PH_ADDR: begin
            ackIt <= addrHit;
            byteSel <= 1'b0;
            phase <= !addrHit ? PH_IGNORE : (byteNow[0] ? PH_RDATA : PH_PTR);
          end
          PH_PTR: begin
            ackIt <= 1'b1;
            byteSel <= 1'b0;
            phase <= PH_WDATA;
          end
          PH_WDATA: begin
            ackIt <= 1'b1;
            byteSel <= ~byteSel;
            if (!byteSel) begin
              msbHold <= byteNow;
            end
          end
          PH_RDATA, PH_IGNORE: begin
            ackIt <= 1'b0;
          end
        endcase
      end
    end
  end

  // hand-off words and toggles; never cleared by start or stop
  always_ff @(posedge serialClock or posedge rst) begin
    if (rst) begin
      xfer <= '0;
      xferTgl <= 1'b0;
      readTgl <= 1'b0;
    end else if (byteDone && !ackSlot) begin
      if (phase == PH_ADDR && addrHit && byteNow[0]) begin
        readTgl <= ~readTgl;
      end
      if (phase == PH_PTR) begin
        xfer <= '{isData: 1'b0, word: {8'h00, byteNow}};
        xferTgl <= ~xferTgl;
      end
      if (phase == PH_WDATA && byteSel) begin
        xfer <= '{isData: 1'b1, word: {msbHold, byteNow}};
        xferTgl <= ~xferTgl;
      end
    end
  end

  // ****************************************************************
  // link domain: data line drive on the falling serial clock
  // ****************************************************************
  // read bit from the snapshot, most significant byte first
  assign txBit = snapshot[{~byteSel, ~bitCnt[2:0]}];

  // ack held from the fall before the ninth rise to the fall after it
  always_ff @(negedge serialClock or posedge linkRst) begin
    if (linkRst) begin
      sdaOe <= 1'b0;
    end else if (ackSlot) begin
      sdaOe <= ackIt;
    end else if (phase == PH_RDATA) begin
      sdaOe <= ~txBit;
    end else begin
      sdaOe <= 1'b0;
    end
  end

  // open-drain data pin only ever pulls low
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sdaOut <= 1'b0;
    end else if (ce) begin
      sdaOut <= 1'b0;
    end
  end

  // ****************************************************************
  // main domain: synchronisers for pins and link toggles
  // ****************************************************************
  assign syncIn = {readTgl, xferTgl, sdaIn, serialClock};

  // three stages; a change is accepted when the second and third agree
  for (genvar i = 0; i < tsp_pkg::SYNC_W; i++) begin : gSync
    logic st1;
    logic st2;
    logic st3;
    logic stable;
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        st1 <= tsp_pkg::SYNC_RESET[i];
        st2 <= tsp_pkg::SYNC_RESET[i];
        st3 <= tsp_pkg::SYNC_RESET[i];
        stable <= tsp_pkg::SYNC_RESET[i];
      end else if (ce) begin
        st1 <= syncIn[i];
        st2 <= st1;
        st3 <= st2;
        if (st2 == st3) begin
          stable <= st3;
        end
      end
    end
    assign filt[i] = stable;
  end

  // ****************************************************************
  // main domain: start, stop and idle clock timeout
  // ****************************************************************
  assign startSeen = filt[tsp_pkg::SYNC_SCL] & prevFilt[tsp_pkg::SYNC_SCL]
                     & prevFilt[tsp_pkg::SYNC_SDA] & ~filt[tsp_pkg::SYNC_SDA];
  assign stopSeen = filt[tsp_pkg::SYNC_SCL] & prevFilt[tsp_pkg::SYNC_SCL]
                    & ~prevFilt[tsp_pkg::SYNC_SDA] & filt[tsp_pkg::SYNC_SDA];
  assign sclEdge = filt[tsp_pkg::SYNC_SCL] ^ prevFilt[tsp_pkg::SYNC_SCL];
  assign timeoutHit = busy && idleTimer == 32'(TIMEOUT_CYCLES - 1);
  assign xferEvt = filt[tsp_pkg::SYNC_XFER] ^ prevFilt[tsp_pkg::SYNC_XFER];
  assign readEvt = filt[tsp_pkg::SYNC_READ] ^ prevFilt[tsp_pkg::SYNC_READ];

  // bus busy flag, stuck-clock timer and link reset pulse
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prevFilt <= tsp_pkg::SYNC_RESET;
      busy <= 1'b0;
      idleTimer <= 32'h0000_0000;
      linkRst <= 1'b1;
    end else if (ce) begin
      prevFilt <= filt;
      busy <= startSeen | (busy & ~stopSeen & ~timeoutHit);
      idleTimer <= (!busy || sclEdge || startSeen) ? 32'h0000_0000 : 32'(idleTimer + 32'h1);
      linkRst <= startSeen | stopSeen | timeoutHit;
    end
  end

  // ****************************************************************
  // main domain: write decode
  // ****************************************************************
  assign dataWrite = xferEvt & xfer.isData;
  assign wrCfg = dataWrite && selector[3:0] == tsp_pkg::PTR_CONFIG;
  assign wrUpper = dataWrite && selector[3:0] == tsp_pkg::PTR_UPPER && !cfg[tsp_pkg::CFG_WIN_LOCK];
  assign wrLower = dataWrite && selector[3:0] == tsp_pkg::PTR_LOWER && !cfg[tsp_pkg::CFG_WIN_LOCK];
  assign wrCrit = dataWrite && selector[3:0] == tsp_pkg::PTR_CRITICAL
                  && !cfg[tsp_pkg::CFG_CRIT_LOCK];
  assign wrRes = dataWrite && selector[3:0] == tsp_pkg::PTR_RESOLUTION;
  assign intClear = wrCfg & xfer.word[tsp_pkg::CFG_INT_CLR];
  // writable bits replaced, lock bits only set, status and clear never stored
  assign next_cfg = (cfg & ~tsp_pkg::CFG_WR_MASK) | (xfer.word & tsp_pkg::CFG_WR_MASK)
                    | (xfer.word & tsp_pkg::CFG_LOCK_MASK);

  // selector and register storage; other targets ignore writes
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      selector <= tsp_pkg::SELECTOR_RESET;
      cfg <= tsp_pkg::CFG_RESET;
      upperLimit <= tsp_pkg::LIMIT_RESET;
      lowerLimit <= tsp_pkg::LIMIT_RESET;
      criticalLimit <= tsp_pkg::LIMIT_RESET;
      resolution <= tsp_pkg::RESOLUTION_RESET;
    end else if (ce) begin
      if (xferEvt && !xfer.isData) begin
        selector <= xfer.word[7:0];
      end
      if (wrCfg) begin
        cfg <= next_cfg;
      end
      if (wrUpper) begin
        upperLimit <= xfer.word & tsp_pkg::LIMIT_MASK;
      end
      if (wrLower) begin
        lowerLimit <= xfer.word & tsp_pkg::LIMIT_MASK;
      end
      if (wrCrit) begin
        criticalLimit <= xfer.word & tsp_pkg::LIMIT_MASK;
      end
      if (wrRes) begin
        resolution <= xfer.word[1:0];
      end
    end
  end

  // ****************************************************************
  // main domain: ambient reading and event output
  // ****************************************************************
  assign aboveUpper = $signed(ambient) > $signed(upperLimit[12:0]);
  assign belowLower = $signed(ambient) < $signed(lowerLimit[12:0]);
  assign atCrit = $signed(ambient) >= $signed(criticalLimit[12:0]);
  assign evtCond = cfg[tsp_pkg::CFG_EVT_SEL] ? atCrit : (aboveUpper | belowLower | atCrit);
  assign evtActive = cfg[tsp_pkg::CFG_EVT_CNT] & ~cfg[tsp_pkg::CFG_POWER_DOWN]
                     & (cfg[tsp_pkg::CFG_EVT_MODE] ? evtLatch : evtCond);

  // reading loaded whole; interrupt latch where a new event beats the clear
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ambient <= tsp_pkg::AMBIENT_RESET;
      evtLatch <= 1'b0;
      eventOe <= 1'b0;
      eventOut <= 1'b0;
    end else if (ce) begin
      if (conversionDone && !cfg[tsp_pkg::CFG_POWER_DOWN]) begin
        ambient <= ambientReading;
      end
      evtLatch <= (evtLatch & ~intClear) | (cfg[tsp_pkg::CFG_EVT_CNT] & evtCond);
      eventOe <= cfg[tsp_pkg::CFG_EVT_POL] ? ~evtActive : evtActive;
      eventOut <= 1'b0;
    end
  end

  assign powerDownSelect = cfg[tsp_pkg::CFG_POWER_DOWN];
  assign resolutionSelect = resolution;

  // ****************************************************************
  // main domain: read view and snapshot for the link
  // ****************************************************************
  assign regView[0] = tsp_pkg::CAP_FIXED
                      | (16'(resolution) << tsp_pkg::CAP_RES_LSB);
  assign regView[1] = cfg | (16'(evtActive) << tsp_pkg::CFG_EVT_STAT);
  assign regView[2] = upperLimit;
  assign regView[3] = lowerLimit;
  assign regView[4] = criticalLimit;
  assign regView[5] = {atCrit, aboveUpper, belowLower, ambient};
  assign regView[6] = MAKER_ID;
  assign regView[7] = PART_ID_REV;
  assign regView[8] = {14'h0000, resolution};
  // selector codes 9 to 15 read as zero; the upper four selector bits are ignored
  for (genvar r = 9; r < 16; r++) begin : gReserved
    assign regView[r] = 16'h0000;
  end
  assign readWord = regView[selector[3:0]];

  // snapshot taken once per addressed read, steady while bits shift out
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      snapshot <= 16'h0000;
    end else if (ce && readEvt) begin
      snapshot <= readWord;
    end
  end

endmodule : tsp_serial_port

`default_nettype wire

// *** test/tsp_checker.sv ***
// tsp_checker: concurrent checks on the ports of the sensor serial port.
// assumes the master keeps serial clock phases well above ten main clock cycles.
`timescale 1ns/100ps
`default_nettype none

module tsp_checker #(
  parameter int unsigned TIMEOUT_CYCLES = 200
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic serialClock,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic eventOut,
  input wire logic eventOe,
  input wire logic powerDownSelect,
  input wire logic [1:0] resolutionSelect
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // ****************************************************************
  // run lengths of each serial clock level, in main clock cycles
  // ****************************************************************
  logic [31:0] hiCnt;
  logic [31:0] loCnt;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hiCnt <= 32'h0;
      loCnt <= 32'h0;
    end else begin
      hiCnt <= serialClock ? hiCnt + 32'h1 : 32'h0;
      loCnt <= serialClock ? 32'h0 : loCnt + 32'h1;
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  chk_drive_starts_low: assert property ($rose(sdaOe) |-> !serialClock)
    else $error("data drive began while serial clock high");
  chk_drive_holds_high: assert property (serialClock && $past(serialClock) |-> $stable(sdaOe))
    else $error("data drive changed during serial clock high");
  chk_open_drain_pins: assert property (sdaOut == 1'b0 && eventOut == 1'b0)
    else $error("open drain pin driven high");
  chk_idle_released: assert property (hiCnt > 32'h28 |-> !sdaOe)
    else $error("data line held after transfer end");
  chk_stuck_clock: assert property (loCnt > TIMEOUT_CYCLES + 16 |-> !sdaOe)
    else $error("serial state not reset by stuck clock");
  chk_reset_levels: assert property ($fell(rst) |-> resolutionSelect == 2'h1 && !eventOe)
    else $error("wrong output levels after reset");
  chk_commit_in_high: assert property (
    $changed({powerDownSelect, resolutionSelect}) |-> serialClock)
    else $error("register commit outside data byte end");
  chk_power_down_event: assert property (
    powerDownSelect && $past(powerDownSelect, 4) |-> !eventOe)
    else $error("event pin active during power down");

  cover property ($rose(eventOe));
  cover property (loCnt == TIMEOUT_CYCLES);
  cover property ($changed(resolutionSelect));
endmodule : tsp_checker

bind tsp_serial_port tsp_checker #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_chk (
  .mclk, .rst, .serialClock, .sdaOut, .sdaOe, .eventOut, .eventOe, .powerDownSelect,
  .resolutionSelect
);

`default_nettype wire

// *** test/tsp_host_model.sv ***
// tsp_host_model: two-wire bus master, serial clock stands high between frames.
// assumes a pull-up resolves the data line from all pull-downs outside.
`timescale 1ns/100ps
`default_nettype none

module tsp_host_model #(
  parameter int PH = 8
) (
  input wire logic linkClk,
  input wire logic sdaLine,
  output var logic sclOut,
  output var logic sdaPull
);
  initial begin
    sclOut = 1'b1;
    sdaPull = 1'b0;
  end

  // ****************************************************************
  // bit level
  // ****************************************************************
  task automatic ph();
    repeat (PH) @(posedge linkClk);
    #1;
  endtask : ph

  task automatic start();
    sdaPull = 1'b1;
    repeat (3) ph();
    sclOut = 1'b0;
    ph();
  endtask : start

  task automatic stop();
    sdaPull = 1'b1;
    ph();
    sclOut = 1'b1;
    ph();
    sdaPull = 1'b0;
    repeat (3) ph();
  endtask : stop

  // data changes only while the clock is low, sampled late in the high phase
  task automatic bit_io(input logic b, output logic r);
    sdaPull = !b;
    ph();
    sclOut = 1'b1;
    ph();
    r = sdaLine;
    sclOut = 1'b0;
    ph();
  endtask : bit_io

  // eight bits then the extra acknowledge clock
  task automatic byte_io(input logic [7:0] d, input logic ackOut, output logic [7:0] q,
      output logic ackSeen);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(!ackOut, r);
    ackSeen = !r;
  endtask : byte_io

  // ****************************************************************
  // register transfers
  // ****************************************************************
  task automatic write_reg(input logic [6:0] addr, input logic [3:0] ptr, input logic [15:0] d,
      input logic withData, output logic ok);
    logic [7:0] q;
    logic a;
    start();
    byte_io({addr, 1'b0}, 1'b0, q, ok);
    byte_io({4'h0, ptr}, 1'b0, q, a);
    ok = ok & a;
    if (withData) begin
      byte_io(d[15:8], 1'b0, q, a);
      ok = ok & a;
      byte_io(d[7:0], 1'b0, q, a);
      ok = ok & a;
    end
    stop();
  endtask : write_reg

  task automatic read_reg(input logic [6:0] addr, output logic [15:0] w);
    logic [7:0] q;
    logic a;
    start();
    byte_io({addr, 1'b1}, 1'b0, q, a);
    byte_io(8'hFF, 1'b1, w[15:8], a);
    byte_io(8'hFF, 1'b0, w[7:0], a);
    stop();
  endtask : read_reg
endmodule : tsp_host_model

`default_nettype wire

// *** test/tb_temp_sensor_serial_register_port.sv ***
// tb_temp_sensor_serial_register_port: self-checking bench for the sensor serial port.
// assumes the host model as bus master and the checker bound to the port.
`timescale 1ns/100ps
`default_nettype none

module tb_temp_sensor_serial_register_port;
  localparam logic [6:0] DEV = {tsp_pkg::SENSOR_ADDR_HI, 3'h5};
  localparam logic [7:0] ADDR_W = {DEV, 1'b0};
  localparam logic [15:0] MAKER = 16'h1234; // arbitrary value
  localparam logic [15:0] PART = 16'h5A01; // arbitrary value
  logic mclk;
  logic linkClk;
  logic rst;
  logic conversionDone;
  logic [12:0] ambientReading;
  logic sdaOe;
  logic eventOe;
  logic powerDownSelect;
  logic [1:0] resolutionSelect;
  logic sclLine;
  logic sdaPull;
  logic sdaLine;
  int bad_count;
  int cmp_count;

  // ****************************************************************
  // clocks, wire resolution and instances
  // ****************************************************************
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  initial begin
    linkClk = 1'b0;
    #1.3;
    forever #3 linkClk = ~linkClk;
  end
  assign sdaLine = ~(sdaOe | sdaPull); // pulled up unless someone pulls low

  tsp_serial_port #(.TIMEOUT_CYCLES(200), .MAKER_ID(MAKER), .PART_ID_REV(PART)) uut (
    .mclk(mclk), .rst(rst), .ce(1'b1), .serialClock(sclLine), .sdaIn(sdaLine), .sdaOut(),
    .sdaOe(sdaOe), .addrSelect(3'h5), .ambientReading(ambientReading),
    .conversionDone(conversionDone), .eventOut(), .eventOe(eventOe),
    .powerDownSelect(powerDownSelect), .resolutionSelect(resolutionSelect));
  tsp_host_model host (.linkClk(linkClk), .sdaLine(sdaLine), .sclOut(sclLine), .sdaPull(sdaPull));

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic clk(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : clk

  task automatic cmp_word(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_word

  task automatic wr(input logic [3:0] p, input logic [15:0] d);
    logic a;
    host.write_reg(DEV, p, d, 1'b1, a);
    cmp_word("write ack", 16'h1, {15'h0, a});
  endtask : wr

  task automatic rd(input logic [3:0] p, input logic [15:0] exp, input string what);
    logic [15:0] q;
    logic a;
    host.write_reg(DEV, p, 16'h0, 1'b0, a);
    host.read_reg(DEV, q);
    cmp_word(what, exp, q);
  endtask : rd

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic sc_reset_values();
    logic [15:0] exp [9] = '{16'h00EF, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, MAKER, PART, 16'h0001};
    for (int i = 0; i < 9; i++) begin
      if (i != 5) rd(4'(i), exp[i], "reset value");
    end
  endtask : sc_reset_values

  task automatic sc_limits();
    logic [15:0] q;
    wr(4'h2, 16'hFFFF);
    rd(4'h2, 16'h1FFC, "upper limit");
    wr(4'h3, 16'h00A3);
    rd(4'h3, 16'h00A0, "lower limit");
    wr(4'h4, 16'h01E0);
    wr(4'h2, 16'h0140);
    host.read_reg(DEV, q);
    cmp_word("kept selector", 16'h0140, q);
  endtask : sc_limits

  task automatic sc_read_only();
    wr(4'h0, 16'hFFFF);
    wr(4'h7, 16'h0000);
    wr(4'h1, 16'hF830);
    rd(4'h0, 16'h00EF, "capability");
    rd(4'h7, PART, "part identity");
    rd(4'h1, 16'h0000, "configuration");
  endtask : sc_read_only

  task automatic sc_ambient();
    logic [12:0] amb [4] = '{13'h0190, 13'h00F0, 13'h01E0, 13'h1FF0};
    logic [15:0] exp [4] = '{16'h4190, 16'h00F0, 16'hC1E0, 16'h3FF0};
    logic ev [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
    wr(4'h1, 16'h0008);
    for (int i = 0; i < 4; i++) begin
      clk(1);
      ambientReading = amb[i];
      conversionDone = 1'b1;
      clk(1);
      conversionDone = 1'b0;
      clk(10);
      cmp_word("event pin", {15'h0, ev[i]}, {15'h0, eventOe});
      rd(4'h5, exp[i], "ambient word");
    end
  endtask : sc_ambient

  task automatic sc_nak_release();
    logic [7:0] q;
    logic a;
    host.start();
    host.byte_io({DEV, 1'b1}, 1'b0, q, a);
    host.byte_io(8'hFF, 1'b1, q, a);
    host.byte_io(8'hFF, 1'b0, q, a);
    cmp_word("released after nak", 16'h0, {15'h0, sdaOe});
    host.stop();
  endtask : sc_nak_release

  task automatic sc_timeout();
    logic r;
    logic [7:0] q;
    logic a;
    host.start();
    for (int i = 7; i >= 0; i--) begin
      host.bit_io(ADDR_W[i], r);
    end
    cmp_word("address ack drive", 16'h1, {15'h0, sdaOe});
    clk(260);
    cmp_word("drive after timeout", 16'h0, {15'h0, sdaOe});
    host.bit_io(1'b1, r);
    host.byte_io(8'h02, 1'b0, q, a);
    cmp_word("ack after timeout", 16'h0, {15'h0, a});
    host.stop();
    rd(4'h2, 16'h0140, "upper after timeout");
  endtask : sc_timeout

  task automatic sc_address();
    logic a;
    host.write_reg({tsp_pkg::SENSOR_ADDR_HI, 3'h2}, 4'h2, 16'h0000, 1'b1, a);
    cmp_word("foreign address ack", 16'h0, {15'h0, a});
    rd(4'h2, 16'h0140, "upper untouched");
  endtask : sc_address

  task automatic sc_power_res();
    wr(4'h1, 16'h0108);
    clk(10);
    cmp_word("power down pin", 16'h1, {15'h0, powerDownSelect});
    cmp_word("event in power down", 16'h0, {15'h0, eventOe});
    wr(4'h8, 16'h0003);
    cmp_word("resolution pins", 16'h3, {14'h0, resolutionSelect});
    rd(4'h0, 16'h00FF, "capability resolution");
  endtask : sc_power_res

  // ****************************************************************
  // main sequence and watchdog
  // ****************************************************************
  initial begin
    rst = 1'b1;
    conversionDone = 1'b0;
    ambientReading = 13'h0000;
    bad_count = 0;
    cmp_count = 0;
    clk(5);
    rst = 1'b0;
    clk(10);
    sc_reset_values();
    sc_limits();
    sc_read_only();
    sc_nak_release();
    sc_timeout();
    sc_address();
    sc_ambient();
    sc_power_res();
    tally_and_finish();
  end

  initial begin
    repeat (100000) @(posedge mclk);
    bad_count++;
    $display("Error run length expected end seen hang");
    tally_and_finish();
  end
endmodule : tb_temp_sensor_serial_register_port

`default_nettype wire
